// ### sgc_top.sv
// Socket global control, card status change flags and I/O window offsets.
// Assumes a same-clock register master, card interrupt pins from outside,
// and status events as one-cycle pulses from same-clock socket logic.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module sgc_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic global_hard_reset_n,
  input wire logic ce,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic card_a_irq_pin,
  input wire logic card_b_irq_pin,
  input wire logic [3:0] status_event,
  input wire logic card_cycle_req,
  output logic card_drive_en,
  output logic host_irq_a,
  output logic host_irq_b,
  output logic csc_irq,
  output logic power_down,
  output logic sw_cd_trigger,
  output logic [15:0] io_win0_offset,
  output logic [15:0] io_win1_offset
);

  logic rst_any;
  logic [1:0] gctrl_hi_r;
  logic [2:0] gctrl_lo_r;
  logic [3:0] csc_r;
  logic [3:0] csc_nxt;
  logic [3:0] mask_r;
  logic swcd_r;
  logic pending_d_r;
  logic csc_irq_r;
  logic a_s1_r;
  logic a_s2_r;
  logic a_d_r;
  logic b_s1_r;
  logic b_s2_r;
  logic b_d_r;
  logic host_irq_a_r;
  logic host_irq_b_r;
  logic card_drive_en_r;
  logic [7:0] reg_rdata_r;

  sgc_win_if win0_if ();
  sgc_win_if win1_if ();

  // Soft reset leaves the sticky control bits alone
  assign rst_any = !resetn || !global_hard_reset_n;

  wire sel_gctrl = reg_addr == sgc_pkg::OFF_GCTRL;
  wire sel_csc = reg_addr == sgc_pkg::OFF_CSC;
  wire sel_mask = reg_addr == sgc_pkg::OFF_CSC_MASK;
  wire sel_cdgen = reg_addr == sgc_pkg::OFF_CD_GEN;
  wire sel_w0l = reg_addr == sgc_pkg::OFF_WIN0_LO;
  wire sel_w0h = reg_addr == sgc_pkg::OFF_WIN0_HI;
  wire sel_w1l = reg_addr == sgc_pkg::OFF_WIN1_LO;
  wire sel_w1h = reg_addr == sgc_pkg::OFF_WIN1_HI;

  wire wr_gctrl = reg_wr && sel_gctrl;
  wire wr_csc = reg_wr && sel_csc;
  wire rd_csc = reg_rd && sel_csc;
  wire wr_mask = reg_wr && sel_mask;
  wire wr_cdgen = reg_wr && sel_cdgen;

  wire lvl_b = gctrl_hi_r[sgc_pkg::GC_IRQ_B_BIT - 3];
  wire lvl_a = gctrl_hi_r[sgc_pkg::GC_IRQ_A_BIT - 3];
  wire ifc_mode = gctrl_lo_r[sgc_pkg::GC_IFC_BIT];
  wire csc_lvl = gctrl_lo_r[sgc_pkg::GC_CSCM_BIT];
  wire pd = gctrl_lo_r[sgc_pkg::GC_PD_BIT];

  // Global control: reserved upper bits are never stored
  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      gctrl_hi_r <= sgc_pkg::GC_HI_RST;
    end else if (ce && wr_gctrl) begin
      gctrl_hi_r <= reg_wdata[4:3];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!global_hard_reset_n) begin
      gctrl_lo_r <= sgc_pkg::GC_LO_RST;
    end else if (ce && wr_gctrl) begin
      gctrl_lo_r <= reg_wdata[2:0];
    end
  end

  // Software card detect only counts while its card detect enable is set
  wire swcd_set = wr_cdgen && reg_wdata[sgc_pkg::SWCD_BIT]
    && mask_r[sgc_pkg::CD_FLAG_BIT];
  wire [3:0] csc_event = status_event
    | {swcd_set, 3'b000};
  wire [3:0] csc_wb_clr = (ifc_mode && wr_csc) ? reg_wdata[3:0] : 4'h0;
  wire [3:0] csc_rd_clr = (!ifc_mode && rd_csc) ? 4'hf : 4'h0;
  // A new event in the clearing cycle survives: set wins over clear
  assign csc_nxt = (csc_r & ~(csc_wb_clr | csc_rd_clr)) | csc_event;

  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      csc_r <= sgc_pkg::CSC_RST;
    end else if (ce) begin
      csc_r <= csc_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      mask_r <= sgc_pkg::MASK_RST;
    end else if (ce && wr_mask) begin
      mask_r <= reg_wdata[3:0];
    end
  end

  wire swcd_wb_clr = csc_wb_clr[sgc_pkg::CD_FLAG_BIT];
  wire swcd_clr = swcd_wb_clr || (!ifc_mode && rd_csc);

  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      swcd_r <= 1'b0;
    end else if (ce && swcd_set) begin
      swcd_r <= 1'b1;
    end else if (ce && swcd_clr) begin
      swcd_r <= 1'b0;
    end
  end

  // Status change interrupt, pulse or level per mode
  wire pending = |(csc_r & mask_r);
  wire csc_irq_nxt = csc_lvl ? pending : (pending && !pending_d_r);

  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      pending_d_r <= 1'b0;
      csc_irq_r <= 1'b0;
    end else if (ce) begin
      pending_d_r <= pending;
      csc_irq_r <= csc_irq_nxt;
    end
  end

  // Card interrupt pins are asynchronous; two stages before any use
  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      a_s1_r <= 1'b0;
      a_s2_r <= 1'b0;
      b_s1_r <= 1'b0;
      b_s2_r <= 1'b0;
    end else if (ce) begin
      a_s1_r <= card_a_irq_pin;
      a_s2_r <= a_s1_r;
      b_s1_r <= card_b_irq_pin;
      b_s2_r <= b_s1_r;
    end
  end

  // Power-down does not gate these paths, so requests still reach the host
  wire host_irq_a_nxt = lvl_a ? a_s2_r : (a_s2_r && !a_d_r);
  wire host_irq_b_nxt = lvl_b ? b_s2_r : (b_s2_r && !b_d_r);

  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      a_d_r <= 1'b0;
      b_d_r <= 1'b0;
      host_irq_a_r <= 1'b0;
      host_irq_b_r <= 1'b0;
    end else if (ce) begin
      a_d_r <= a_s2_r;
      b_d_r <= b_s2_r;
      host_irq_a_r <= host_irq_a_nxt;
      host_irq_b_r <= host_irq_b_nxt;
    end
  end

  // Card outputs float in power-down except during an access; outputs are
  // released during reset so a sticky power-down is never violated
  wire card_drive_nxt = !pd || card_cycle_req;

  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      card_drive_en_r <= 1'b0;
    end else if (ce) begin
      card_drive_en_r <= card_drive_nxt;
    end
  end

  assign win0_if.wr_lo = reg_wr && sel_w0l;
  assign win0_if.wr_hi = reg_wr && sel_w0h;
  assign win0_if.wdata = reg_wdata;
  assign win1_if.wr_lo = reg_wr && sel_w1l;
  assign win1_if.wr_hi = reg_wr && sel_w1h;
  assign win1_if.wdata = reg_wdata;

  sgc_io_window u_win0 (
    .sys_clk(sys_clk),
    .clear(rst_any),
    .ce(ce),
    .win(win0_if)
  );

  sgc_io_window u_win1 (
    .sys_clk(sys_clk),
    .clear(rst_any),
    .ce(ce),
    .win(win1_if)
  );

  // Read mux; the trigger register is write-only and reads zero
  wire [7:0] rd_word =
    sel_gctrl ? {3'b000, gctrl_hi_r, gctrl_lo_r} :
    sel_csc ? {4'h0, csc_r} :
    sel_mask ? {4'h0, mask_r} :
    sel_w0l ? win0_if.offset[7:0] :
    sel_w0h ? win0_if.offset[15:8] :
    sel_w1l ? win1_if.offset[7:0] :
    sel_w1h ? win1_if.offset[15:8] :
    sgc_pkg::RDATA_IDLE;

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst_any) begin
      reg_rdata_r <= sgc_pkg::RDATA_IDLE;
    end else if (ce) begin
      reg_rdata_r <= reg_rd ? rd_word : sgc_pkg::RDATA_IDLE;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign card_drive_en = card_drive_en_r;
  assign host_irq_a = host_irq_a_r;
  assign host_irq_b = host_irq_b_r;
  assign csc_irq = csc_irq_r;
  assign power_down = pd;
  assign sw_cd_trigger = swcd_r;
  assign io_win0_offset = win0_if.offset;
  assign io_win1_offset = win1_if.offset;

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (rst_any);

  rsvd_zero_a: assert property (
    (ce && reg_rd && sel_gctrl) |=> reg_rdata[7:5] == 3'b000)
    else $error("reserved control bits read nonzero");

  irq_b_edge_a: assert property (
    (ce && !lvl_b && host_irq_b && !wr_gctrl) |=> !host_irq_b)
    else $error("card B edge interrupt longer than one cycle");

  irq_a_level_a: assert property (
    (ce && lvl_a) |=> host_irq_a == $past(a_s2_r))
    else $error("card A level interrupt does not follow pin");

  rd_clear_a: assert property (
    (ce && rd_csc && !ifc_mode && status_event == 4'h0) |=> csc_r == 4'h0)
    else $error("status flags not cleared by read");

  wb_keep_a: assert property (
    (ce && rd_csc && ifc_mode)
      |=> csc_r == ($past(csc_r) | $past(status_event)))
    else $error("status flags lost on read in write-back mode");

  csc_edge_a: assert property (
    (ce && !csc_lvl && csc_irq && !wr_gctrl) |=> !csc_irq)
    else $error("status change edge interrupt too long");

  pd_float_a: assert property (
    (ce && pd && !card_cycle_req) |=> !card_drive_en)
    else $error("card outputs driven in power-down without access");

  pd_release_a: assert property (
    (ce && pd && card_cycle_req) ##1 (ce && pd && !card_cycle_req)
      |=> !card_drive_en)
    else $error("card outputs not released after access");

  pd_irq_a: assert property (
    (ce && pd && lvl_b) |=> host_irq_b == $past(b_s2_r))
    else $error("card interrupt blocked in power-down");

  sticky_ctrl_a: assert property (
    @(posedge sys_clk) disable iff (!global_hard_reset_n)
    (!resetn && !wr_gctrl) |=> gctrl_lo_r == $past(gctrl_lo_r))
    else $error("sticky control bits changed by soft reset");

  lo_bit0_a: assert property (
    (ce && reg_rd && (sel_w0l || sel_w1l)) |=> reg_rdata[0] == 1'b0)
    else $error("window low byte bit 0 reads one");

  hi_rdback_a: assert property (
    (ce && reg_wr && sel_w1h) ##1 (ce && reg_rd && sel_w1h)
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("window high byte read back wrong");

  trig_clear_a: assert property (
    (ce && ifc_mode && wr_csc && reg_wdata[sgc_pkg::CD_FLAG_BIT])
      |=> !sw_cd_trigger)
    else $error("software trigger kept after write-back clear");

  pd_wake_c: cover property (
    (ce && pd && card_cycle_req) ##1 card_drive_en ##1 !card_drive_en);

  rd_clear_c: cover property (
    (csc_r != 4'h0) ##1 (ce && rd_csc && !ifc_mode));

  edge_pulse_c: cover property (!lvl_a && host_irq_a);

  trig_clear_c: cover property (sw_cd_trigger ##1 (ce && ifc_mode && wr_csc));

endmodule
`default_nettype wire

// ### sgc_pkg.sv
// Constants shared by the socket global control block and its window module.
// Assumes an 8-bit register port at the printed socket offsets, one clock.
// Notes on behaviour
// - Global control bits 7 to 5 read zero and ignore writes.
// - Bit 4 picks card B interrupt signalling: 0 edge (default), 1 level.
// - Bit 3 picks card A interrupt signalling: 0 edge (default), 1 level.
// - Bit 2 picks flag clearing: 0 clear on read, 1 clear by writing one.
// - Bit 1 picks status change interrupt signalling: 0 edge, 1 level.
// - Bit 0 set floats card outputs until an active card cycle runs.
// - In power-down, outputs float again after each active card cycle.
// - Power-down still takes card interrupts; only a card access wakes outputs.
// - Global control bits 2 to 0 clear only on global hard reset.
// - Window low byte holds offset bits 7 to 0; bit 0 reads zero.
// - Window high byte holds offset bits 15 to 8, all read/write, reset zero.
// - Write-back clear of card detect flag also clears software trigger bit.
package sgc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int CSC_W = 4;

  localparam logic [11:0] OFF_CSC = 12'h804;
  localparam logic [11:0] OFF_CSC_MASK = 12'h805;
  localparam logic [11:0] OFF_CD_GEN = 12'h816;
  localparam logic [11:0] OFF_GCTRL = 12'h81e;
  localparam logic [11:0] OFF_WIN0_LO = 12'h836;
  localparam logic [11:0] OFF_WIN0_HI = 12'h837;
  localparam logic [11:0] OFF_WIN1_LO = 12'h838;
  localparam logic [11:0] OFF_WIN1_HI = 12'h839;

  localparam int GC_IRQ_B_BIT = 4;
  localparam int GC_IRQ_A_BIT = 3;
  localparam int GC_IFC_BIT = 2;
  localparam int GC_CSCM_BIT = 1;
  localparam int GC_PD_BIT = 0;
  localparam int CD_FLAG_BIT = 3;
  localparam int SWCD_BIT = 5;

  localparam logic [1:0] GC_HI_RST = 2'h0;
  localparam logic [2:0] GC_LO_RST = 3'h0;
  localparam logic [3:0] CSC_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [6:0] WIN_LO_RST = 7'h00;
  localparam logic [7:0] WIN_HI_RST = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

endpackage

// ### sgc_win_if.sv
// Interface between the register decoder and one I/O window register pair.
// Assumes both ends run on the same clock as the top module.
`timescale 1ns/100ps
`default_nettype none
interface sgc_win_if;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata;
  logic [15:0] offset;

  modport regs (
    input wr_lo,
    input wr_hi,
    input wdata,
    output offset
  );

  modport ctrl (
    output wr_lo,
    output wr_hi,
    output wdata,
    input offset
  );
endinterface
`default_nettype wire

// ### sgc_io_window.sv
// One 16-bit I/O window offset, stored as a low byte and a high byte.
// Assumes single-cycle write strobes from the decoder on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sgc_io_window (
  input wire logic sys_clk,
  input wire logic clear,
  input wire logic ce,
  sgc_win_if.regs win
);

  // Bit 0 is not stored at all, so no write can ever set it
  logic [6:0] lo_r;
  logic [7:0] hi_r;

  always_ff @(posedge sys_clk) begin
    if (clear) begin
      lo_r <= sgc_pkg::WIN_LO_RST;
    end else if (ce && win.wr_lo) begin
      lo_r <= win.wdata[7:1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clear) begin
      hi_r <= sgc_pkg::WIN_HI_RST;
    end else if (ce && win.wr_hi) begin
      hi_r <= win.wdata;
    end
  end

  assign win.offset = {hi_r, lo_r, 1'b0};

  lo_write_a: assert property (
    @(posedge sys_clk) disable iff (clear)
    (ce && win.wr_lo) |=> win.offset[7:0] == {$past(win.wdata[7:1]), 1'b0}
      && win.offset[15:8] == $past(win.offset[15:8]))
    else $error("low byte write did not land in offset");

  hi_write_a: assert property (
    @(posedge sys_clk) disable iff (clear)
    (ce && win.wr_hi) |=> win.offset[15:8] == $past(win.wdata)
      && win.offset[7:0] == $past(win.offset[7:0]))
    else $error("high byte write did not land in offset");

endmodule
`default_nettype wire

// ### sgc_card_model.sv
// Behavioural card in the socket: interrupt pins and status change events.
// Assumes the bench asks for levels and one-cycle events on the block clock.
`timescale 1ns/100ps
`default_nettype none
module sgc_card_model (
  input wire logic sys_clk,
  input wire logic irq_a_req,
  input wire logic irq_b_req,
  input wire logic [3:0] event_req,
  output logic card_a_irq_pin,
  output logic card_b_irq_pin,
  output logic [3:0] status_event
);
  // Unknown until the first edge; reset in the block covers that span

  // A real card changes its pins on its own; one flop delay stands for that
  always @(posedge sys_clk) begin
    card_a_irq_pin <= irq_a_req;
    card_b_irq_pin <= irq_b_req;
    status_event <= event_req;
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the socket global control block.
// Assumes the card model drives the card pins; clock enable dropped once.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic global_hard_reset_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic card_cycle_req = 1'b0;
  logic ce = 1'b1;
  logic irq_a_req = 1'b0;
  logic irq_b_req = 1'b0;
  logic [3:0] event_req = 4'h0;
  wire [7:0] reg_rdata;
  wire card_a_irq_pin;
  wire card_b_irq_pin;
  wire [3:0] status_event;
  wire card_drive_en;
  wire host_irq_a;
  wire host_irq_b;
  wire csc_irq;
  wire power_down;
  wire sw_cd_trigger;
  wire [15:0] io_win0_offset;
  wire [15:0] io_win1_offset;
  int errors = 0;
  int checked = 0;

  always #5 sys_clk = ~sys_clk;

  sgc_top u_sgc_top (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .global_hard_reset_n(global_hard_reset_n),
    .ce(ce),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .card_a_irq_pin(card_a_irq_pin),
    .card_b_irq_pin(card_b_irq_pin),
    .status_event(status_event),
    .card_cycle_req(card_cycle_req),
    .card_drive_en(card_drive_en),
    .host_irq_a(host_irq_a),
    .host_irq_b(host_irq_b),
    .csc_irq(csc_irq),
    .power_down(power_down),
    .sw_cd_trigger(sw_cd_trigger),
    .io_win0_offset(io_win0_offset),
    .io_win1_offset(io_win1_offset)
  );

  sgc_card_model u_sgc_card_model (
    .sys_clk(sys_clk),
    .irq_a_req(irq_a_req),
    .irq_b_req(irq_b_req),
    .event_req(event_req),
    .card_a_irq_pin(card_a_irq_pin),
    .card_b_irq_pin(card_b_irq_pin),
    .status_event(status_event)
  );

  task automatic give_verdict();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // Write then read of one address with no idle cycle between strobes
  task automatic wr_rd(input logic [11:0] a, input logic [7:0] d,
    input logic [7:0] exp);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // Counts cycles each host interrupt is high over a fixed span
  task automatic cnt(output int na, output int nb, output int nc);
    na = 0;
    nb = 0;
    nc = 0;
    repeat (10) begin
      cyc(1);
      na += (host_irq_a === 1'b1);
      nb += (host_irq_b === 1'b1);
      nc += (csc_irq === 1'b1);
    end
  endtask

  task automatic pulse_event(input logic [3:0] e);
    @(posedge sys_clk);
    event_req <= e;
    @(posedge sys_clk);
    event_req <= 4'h0;
  endtask

  task automatic t_reset_values();
    rd_chk(12'h81e, 8'h00);
    rd_chk(12'h836, 8'h00);
    rd_chk(12'h837, 8'h00);
    rd_chk(12'h838, 8'h00);
    rd_chk(12'h839, 8'h00);
    wr(12'h800, 8'hff);
    rd_chk(12'h800, 8'h00);
  endtask

  task automatic t_gctrl_and_windows();
    wr(12'h81e, 8'hff);
    rd_chk(12'h81e, 8'h1f);
    chk(power_down, 1'b1);
    wr(12'h836, 8'hff);
    wr(12'h837, 8'ha5);
    wr(12'h838, 8'h3c);
    wr(12'h839, 8'h5a);
    chk(io_win0_offset, 16'ha5fe);
    chk(io_win1_offset, 16'h5a3c);
    rd_chk(12'h836, 8'hfe);
    rd_chk(12'h837, 8'ha5);
    rd_chk(12'h838, 8'h3c);
    rd_chk(12'h839, 8'h5a);
    wr_rd(12'h839, 8'hc3, 8'hc3);
    wr_rd(12'h836, 8'h81, 8'h80);
    chk(io_win1_offset, 16'hc33c);
    chk(io_win0_offset, 16'ha580);
  endtask

  task automatic t_resets();
    @(posedge sys_clk);
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    rd_chk(12'h81e, 8'h07);
    chk(io_win0_offset, 16'h0000);
    @(posedge sys_clk);
    global_hard_reset_n <= 1'b0;
    cyc(2);
    global_hard_reset_n <= 1'b1;
    rd_chk(12'h81e, 8'h00);
  endtask

  task automatic t_power_down();
    wr(12'h81e, 8'h01);
    cyc(2);
    chk(card_drive_en, 1'b0);
    card_cycle_req <= 1'b1;
    cyc(2);
    chk(card_drive_en, 1'b1);
    card_cycle_req <= 1'b0;
    cyc(2);
    chk(card_drive_en, 1'b0);
  endtask

  // Power-down stays on here: interrupts must still come through
  task automatic t_card_irq();
    int na;
    int nb;
    int nc;
    wr(12'h81e, 8'h09);
    irq_a_req <= 1'b1;
    irq_b_req <= 1'b1;
    cnt(na, nb, nc);
    chk(na >= 5 && host_irq_a === 1'b1, 1'b1);
    chk(nb, 16'h1);
    irq_a_req <= 1'b0;
    irq_b_req <= 1'b0;
    wr(12'h81e, 8'h11);
    cnt(na, nb, nc);
    irq_a_req <= 1'b1;
    irq_b_req <= 1'b1;
    cnt(na, nb, nc);
    chk(na, 16'h1);
    chk(nb >= 5 && host_irq_b === 1'b1, 1'b1);
    irq_a_req <= 1'b0;
    irq_b_req <= 1'b0;
    cnt(na, nb, nc);
    chk(host_irq_b, 1'b0);
  endtask

  task automatic t_status_change();
    int na;
    int nb;
    int nc;
    wr(12'h805, 8'h0f);
    wr(12'h81e, 8'h00);
    pulse_event(4'h1);
    cnt(na, nb, nc);
    chk(nc, 16'h1);
    rd_chk(12'h804, 8'h01);
    rd_chk(12'h804, 8'h00);
    wr(12'h81e, 8'h06);
    pulse_event(4'h2);
    cnt(na, nb, nc);
    chk(nc >= 5 && csc_irq === 1'b1, 1'b1);
    rd_chk(12'h804, 8'h02);
    rd_chk(12'h804, 8'h02);
    wr(12'h804, 8'h02);
    rd_chk(12'h804, 8'h00);
    cyc(3);
    chk(csc_irq, 1'b0);
    wr(12'h816, 8'h20);
    chk(sw_cd_trigger, 1'b1);
    rd_chk(12'h804, 8'h08);
    wr(12'h804, 8'h08);
    cyc(1);
    chk(sw_cd_trigger, 1'b0);
  endtask

  // Clock enable low: a write must not land anywhere
  task automatic t_clock_enable();
    ce <= 1'b0;
    wr(12'h837, 8'h77);
    chk(io_win0_offset, 16'h0000);
    ce <= 1'b1;
    rd_chk(12'h837, 8'h00);
  endtask

  initial begin
    cyc(16);
    resetn <= 1'b1;
    global_hard_reset_n <= 1'b1;
    t_reset_values();
    t_gctrl_and_windows();
    t_resets();
    t_power_down();
    t_card_irq();
    t_status_change();
    t_clock_enable();
    give_verdict();
  end
endmodule
`default_nettype wire
